// ### shared/cfm_pkg.sv
/*
 * Fault monitor constants: timing, register map,
 * status fields and modes.
 * Assumes a 125 MHz device clock and a 32-bit Avalon-MM register slave.
 */
`default_nettype none

package cfm_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_PERIOD_NS   = 8;
    localparam int DTO_TIME_US     = 1200;
    localparam int BUSDOM_TIME_US  = 2600;
    // Least times round up to whole cycles
    localparam int DTO_CYCLES      = (DTO_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSDOM_CYCLES   = (BUSDOM_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W           = 24;
    localparam int EDGE_RUN        = 4;
    localparam int RUN_W           = 3;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam int ADDR_W          = 4;
    localparam int DATA_W          = 32;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MODE     = 4'h4;
    localparam logic [ADDR_W-1:0] REG_DTO_LIM  = 4'h8;
    localparam logic [ADDR_W-1:0] REG_DOM_LIM  = 4'hC;
    localparam logic [DATA_W-1:0] RD_UNMAPPED  = 32'h0000_0000;

    // ==========================================================
    // Status fields
    // ==========================================================
    localparam int ST_BUS_SHORT    = 0;
    localparam int ST_TX_LOW       = 1;
    localparam int ST_TX_DTO       = 2;
    localparam int ST_TXRX_SHORT   = 3;
    localparam int ST_BUS_DOM      = 4;
    localparam int ST_THERMAL      = 5;
    localparam int ST_DRV_EN       = 6;
    localparam int ST_LOCAL_IND    = 7;
    localparam int ST_FAULT_N      = 8;
    localparam int ST_MODE_LSB     = 12;
    localparam int MODE_W          = 3;

    // ==========================================================
    // Operating modes, Gray coded
    // ==========================================================
    typedef enum logic [MODE_W-1:0] {
        CFM_NORMAL    = 3'h0,
        CFM_SILENT    = 3'h1,
        CFM_STANDBY   = 3'h3,
        CFM_GO_SLEEP  = 3'h2,
        CFM_SLEEP     = 3'h6
    } cfm_mode_t;

    localparam cfm_mode_t MODE_RESET = CFM_STANDBY;

endpackage

`default_nettype wire

// ### hw/cfm_dur_timer.sv
/*
 * Duration timer: counts cycles while a condition holds,
 * flags when the count reaches the limit.
 * Assumes the limit is steady while the condition holds.
 */
`default_nettype none

module cfm_dur_timer (
    // Clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_rst_n,
    // Condition and limit
    input  wire logic                      i_run,
    input  wire logic [cfm_pkg::TMR_W-1:0] i_limit,
    // Result
    output logic                           o_expired
);
    import cfm_pkg::*;

    logic [TMR_W-1:0] cnt_reg;

    // ==========================================================
    // Saturates so a long hold cannot wrap
    // ==========================================================
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
        end else if (!i_run) begin
            cnt_reg <= '0;
        end else if (cnt_reg != i_limit) begin
            cnt_reg <= cnt_reg + TMR_W'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_expired <= 1'b0;
        end else begin
            o_expired <= i_run && (cnt_reg >= i_limit);
        end
    end

endmodule

`default_nettype wire

// ### hw/cfm_run_count.sv
/*
 * Run counter: counts consecutive steps with i_hit high;
 * a miss restarts the run.
 * Assumes i_step is a one-cycle pulse.
 */
`default_nettype none

module cfm_run_count (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // Steps
    input  wire logic i_step,
    input  wire logic i_hit,
    // Pulse on the step that completes a run
    output logic      o_full
);
    import cfm_pkg::*;

    logic [RUN_W-1:0] run_reg;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_reg <= '0;
            o_full  <= 1'b0;
        end else begin
            o_full <= 1'b0;
            if (i_step) begin
                if (!i_hit) begin
                    run_reg <= '0;
                end else if (run_reg == RUN_W'(EDGE_RUN - 1)) begin
                    // Next run needs fresh steps
                    run_reg <= '0;
                    o_full  <= 1'b1;
                end else begin
                    run_reg <= run_reg + RUN_W'(1);
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### hw/cfm_fault_monitor.sv
/*
 * Fault monitor of a CAN transceiver: six fault flags, driver
 * gating, fault pin and an Avalon-MM register slave.
 * Assumes inputs synchronous to i_ref_clk; the short detectors
 * and the temperature sensor are analogue front ends with clean
 * levels.
 */
// Implementation choices: the Avalon-MM slave port and the address map.
`default_nettype none

// Operation
// (RULE1) Shorts sampled only while driving dominant.
// (RULE2) Four shorted tx rises set short flag; pin low in normal.
// (RULE3) Short flag keeps driver on.
// (RULE4) Four clean tx rises in normal clear short flag.
// (RULE5) Tx low on entering normal sets clamp, driver off.
// (RULE6) Clamp clears at reset, clean entry, or tx high with bus dominant; held here while another local flag is set.
// (RULE7) Local faults shown on the pin after normal-to-silent.
// (RULE8) Other mode changes clear the local indication.
// (RULE9) Receive output follows the bus in all faults.
// (RULE10) Tx dominant past timeout turns driver off.
// (RULE11) Timeout flag clears on tx rise or non-silent mode entry.
// (RULE12) Tx/rx short for timeout sets flag, driver off.
// (RULE13) Tx/rx short clears on tx rise with bus dominant, or mode entry; silent entry keeps it here.
// (RULE14) Bus dominant past limit sets stuck flag.
// (RULE15) Stuck flag clears on bus rise or mode entry; silent entry keeps it here.
// (RULE16) Over-temperature turns driver off until it clears.
// (RULE17) Thermal shutdown shown on fault pin.
// (RULE18) Stuck flag keeps driver on.
// (RULE19) Times are cycle counts against writable limits.
// (RULE20) Controller releases tx before the timeout.
module cfm_fault_monitor #(
    parameter int P_DTO_CYCLES    = cfm_pkg::DTO_CYCLES,
    parameter int P_BUSDOM_CYCLES = cfm_pkg::BUSDOM_CYCLES
) (
    // Clock and reset
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst_n,
    // Controller side
    input  wire logic                       i_tx,
    output logic                            o_rx,
    output logic                            o_fault_n,
    // Bus front end
    input  wire logic                       i_bus_rx,
    input  wire logic                       i_bus_short,
    input  wire logic                       i_txrx_short,
    input  wire logic                       i_over_temp,
    output logic                            o_drv_en,
    output logic                            o_drv_tx,
    // Avalon-MM register slave
    input  wire logic [cfm_pkg::ADDR_W-1:0] i_avs_address,
    input  wire logic                       i_avs_read,
    input  wire logic                       i_avs_write,
    input  wire logic [cfm_pkg::DATA_W-1:0] i_avs_writedata,
    input  wire logic [3:0]                 i_avs_byteenable,
    output logic [cfm_pkg::DATA_W-1:0]      o_avs_readdata,
    output logic                            o_avs_waitrequest
);
    import cfm_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    cfm_mode_t          mode_reg;
    cfm_mode_t          mode_next;
    logic               mode_chg;
    logic               to_norm_grp;
    logic               enter_norm;
    logic               norm_to_sil;
    logic [TMR_W-1:0]   dto_lim_reg;
    logic [TMR_W-1:0]   dom_lim_reg;
    logic               tx_prev_reg;
    logic               rx_prev_reg;
    logic               tx_rise;
    logic               rx_rise;
    logic               short_seen_reg;
    logic               bus_short_flag_reg;
    logic               tx_stuck_low_flag_reg;
    logic               tx_dominant_timeout_flag_reg;
    logic               tx_rx_short_flag_reg;
    logic               bus_stuck_dominant_flag_reg;
    logic               thermal_shutdown_flag_reg;
    logic               local_ind_reg;
    logic               any_local;
    logic               drv_ok;
    logic               short_set;
    logic               short_clr;
    logic               dto_exp;
    logic               dom_exp;
    logic               txrx_exp;
    logic               bus_req;
    logic               bus_wr;
    logic [DATA_W-1:0]  status;
    logic [DATA_W-1:0]  rd_mux;

    // ==========================================================
    // Edge detection
    // ==========================================================
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_prev_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            tx_prev_reg <= i_tx;
            rx_prev_reg <= i_bus_rx;
        end
    end

    assign tx_rise = i_tx && !tx_prev_reg;
    assign rx_rise = i_bus_rx && !rx_prev_reg;

    // ==========================================================
    // Register bus: one wait cycle, then the answer
    // ==========================================================
    assign bus_req = i_avs_read || i_avs_write;
    assign bus_wr  = i_avs_write && !o_avs_waitrequest;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            // High again after each answer so requests never merge
            o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
        end
    end

    always_comb begin
        status = '0;
        status[ST_BUS_SHORT]  = bus_short_flag_reg;
        status[ST_TX_LOW]     = tx_stuck_low_flag_reg;
        status[ST_TX_DTO]     = tx_dominant_timeout_flag_reg;
        status[ST_TXRX_SHORT] = tx_rx_short_flag_reg;
        status[ST_BUS_DOM]    = bus_stuck_dominant_flag_reg;
        status[ST_THERMAL]    = thermal_shutdown_flag_reg;
        status[ST_DRV_EN]     = o_drv_en;
        status[ST_LOCAL_IND]  = local_ind_reg;
        status[ST_FAULT_N]    = o_fault_n;
        status[ST_MODE_LSB +: MODE_W] = mode_reg;
    end

    always_comb begin
        case (i_avs_address)
            REG_STATUS:  rd_mux = status;
            REG_MODE:    rd_mux = DATA_W'(mode_reg);
            REG_DTO_LIM: rd_mux = DATA_W'(dto_lim_reg);
            REG_DOM_LIM: rd_mux = DATA_W'(dom_lim_reg);
            default:     rd_mux = RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && o_avs_waitrequest) begin
            o_avs_readdata <= rd_mux;
        end
    end

    // Byte-lane merge for the limits
    function automatic logic [TMR_W-1:0] be_merge(input logic [TMR_W-1:0] old_v,
                                                  input logic [DATA_W-1:0] wd,
                                                  input logic [3:0]        be);
        logic [DATA_W-1:0] v;
        v = DATA_W'(old_v);
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                v[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return v[TMR_W-1:0];
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dto_lim_reg <= TMR_W'(P_DTO_CYCLES);
            dom_lim_reg <= TMR_W'(P_BUSDOM_CYCLES);
        end else if (bus_wr) begin
            // Limits stand for analogue times (RULE19)
            if (i_avs_address == REG_DTO_LIM) begin
                dto_lim_reg <= be_merge(dto_lim_reg, i_avs_writedata, i_avs_byteenable);
            end
            if (i_avs_address == REG_DOM_LIM) begin
                dom_lim_reg <= be_merge(dom_lim_reg, i_avs_writedata, i_avs_byteenable);
            end
        end
    end

    // ==========================================================
    // Operating mode
    // ==========================================================
    always_comb begin
        mode_next = mode_reg;
        if (bus_wr && i_avs_address == REG_MODE && i_avs_byteenable[0]) begin
            case (i_avs_writedata[MODE_W-1:0])
                CFM_NORMAL:   mode_next = CFM_NORMAL;
                CFM_SILENT:   mode_next = CFM_SILENT;
                CFM_STANDBY:  mode_next = CFM_STANDBY;
                CFM_GO_SLEEP: mode_next = CFM_GO_SLEEP;
                CFM_SLEEP:    mode_next = CFM_SLEEP;
                // Undefined codes leave the mode alone
                default:      mode_next = mode_reg;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_reg <= MODE_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign mode_chg    = mode_next != mode_reg;
    assign enter_norm  = mode_chg && mode_next == CFM_NORMAL;
    assign norm_to_sil = mode_chg && mode_reg == CFM_NORMAL && mode_next == CFM_SILENT;
    assign to_norm_grp = mode_chg && mode_next != CFM_SILENT;

    // ==========================================================
    // Bus short: sampled per dominant bit, judged at each tx rise
    // ==========================================================
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            short_seen_reg <= 1'b0;
        end else if (tx_rise) begin
            short_seen_reg <= 1'b0;
        end else if (o_drv_en && !o_drv_tx && i_bus_short) begin
            short_seen_reg <= 1'b1; // RULE1
        end
    end

    cfm_run_count u_short_bad (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_step    (tx_rise),
        .i_hit     (short_seen_reg),
        .o_full    (short_set)
    );

    cfm_run_count u_short_good (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_step    (tx_rise),
        .i_hit     (!short_seen_reg),
        .o_full    (short_clr)
    );

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_short_flag_reg <= 1'b0;
        end else if (short_set) begin
            bus_short_flag_reg <= 1'b1; // RULE2
        end else if (short_clr && mode_reg == CFM_NORMAL) begin
            bus_short_flag_reg <= 1'b0; // RULE4
        end
    end

    // ==========================================================
    // Duration timers
    // ==========================================================
    cfm_dur_timer u_dto_tmr (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_run     (!i_tx && o_drv_en && !tx_dominant_timeout_flag_reg), // RULE10
        .i_limit   (dto_lim_reg),
        .o_expired (dto_exp)
    );

    cfm_dur_timer u_txrx_tmr (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_run     (i_txrx_short && !tx_rx_short_flag_reg),
        .i_limit   (dto_lim_reg),
        .o_expired (txrx_exp)
    );

    cfm_dur_timer u_dom_tmr (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_run     (!i_bus_rx && !bus_stuck_dominant_flag_reg),
        .i_limit   (dom_lim_reg),
        .o_expired (dom_exp)
    );

    // ==========================================================
    // Local fault flags; set wins over clear
    // ==========================================================
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_dominant_timeout_flag_reg <= 1'b0;
        end else if (dto_exp) begin
            tx_dominant_timeout_flag_reg <= 1'b1; // RULE10
        end else if (tx_rise || to_norm_grp) begin
            tx_dominant_timeout_flag_reg <= 1'b0; // RULE11
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_rx_short_flag_reg <= 1'b0;
        end else if (txrx_exp) begin
            tx_rx_short_flag_reg <= 1'b1; // RULE12
        end else if ((tx_rise && !i_bus_rx) || to_norm_grp) begin
            tx_rx_short_flag_reg <= 1'b0; // RULE13
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_stuck_dominant_flag_reg <= 1'b0;
        end else if (dom_exp) begin
            bus_stuck_dominant_flag_reg <= 1'b1; // RULE14
        end else if (rx_rise || to_norm_grp) begin
            bus_stuck_dominant_flag_reg <= 1'b0; // RULE15
        end
    end

    // Other local faults hold the clamp
    assign any_local = tx_dominant_timeout_flag_reg || tx_rx_short_flag_reg
                    || bus_stuck_dominant_flag_reg;

    // Reset is power-up: clamp clear (RULE6)
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_stuck_low_flag_reg <= 1'b0;
        end else if (enter_norm && !i_tx) begin
            tx_stuck_low_flag_reg <= 1'b1; // RULE5
        end else if (!any_local && ((enter_norm && i_tx) || (i_tx && !i_bus_rx))) begin
            tx_stuck_low_flag_reg <= 1'b0; // RULE6
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            thermal_shutdown_flag_reg <= 1'b0;
        end else begin
            // Hysteresis is in the sensor
            thermal_shutdown_flag_reg <= i_over_temp; // RULE16
        end
    end

    // ==========================================================
    // Local fault indication
    // ==========================================================
    // Detected in every mode except the tx timeout, which needs the driver on, and the clamp, set on entering normal;
    // shown only after normal-to-silent and while a flag remains.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            local_ind_reg <= 1'b0;
        end else if (norm_to_sil) begin
            local_ind_reg <= 1'b1; // RULE7
        end else if (mode_chg) begin
            local_ind_reg <= 1'b0; // RULE8
        end
    end

    // ==========================================================
    // Driver gating and pins
    // ==========================================================
    // Bus short and stuck flags leave the driver on (RULE3, RULE18)
    assign drv_ok = mode_next == CFM_NORMAL
                 && !tx_stuck_low_flag_reg     // RULE5
                 && !tx_dominant_timeout_flag_reg
                 && !tx_rx_short_flag_reg      // RULE12
                 && !i_over_temp               // RULE16
                 && !(enter_norm && !i_tx)
                 && !dto_exp
                 && !txrx_exp;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_drv_en <= 1'b0;
            o_drv_tx <= 1'b1;
        end else begin
            o_drv_en <= drv_ok;
            // Recessive whenever the driver is off (RULE10)
            o_drv_tx <= drv_ok ? i_tx : 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx <= 1'b1;
        end else begin
            o_rx <= i_bus_rx; // RULE9
        end
    end

    // Tx must rise before the timeout (RULE20)
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fault_n <= 1'b1;
        end else begin
            o_fault_n <= !((bus_short_flag_reg && mode_reg == CFM_NORMAL) // RULE2
                        || thermal_shutdown_flag_reg                    // RULE17
                        || (local_ind_reg && (any_local || tx_stuck_low_flag_reg)));
        end
    end

endmodule

`default_nettype wire

// ### tb/cfm_fault_monitor_asserts.sv
/* Port checker of the fault monitor, bound below.
   Assumes one clock domain. */
`default_nettype none
module cfm_fault_monitor_asserts #(parameter int P_DTO_CYCLES = 20, parameter int P_BUSDOM_CYCLES = 40) (
    input wire logic i_ref_clk, i_rst_n, i_tx, i_txrx_short, i_over_temp, i_bus_rx,
    input wire logic i_avs_read, i_avs_write, o_avs_waitrequest, o_rx, o_fault_n, o_drv_en, o_drv_tx
);
    timeunit 1ns;
    timeprecision 1ps;
    int lo_cnt;
    int sh_cnt;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lo_cnt <= 0;
            sh_cnt <= 0;
        end else begin
            lo_cnt <= (!i_tx && o_drv_en) ? lo_cnt + 1 : 0;
            sh_cnt <= (i_txrx_short && o_drv_en) ? sh_cnt + 1 : 0;
        end
    end
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Slack covers the register stages
    dto_cut_a: assert property (lo_cnt <= P_DTO_CYCLES + 4) else $error("tx dominant past timeout");
    txrx_cut_a: assert property (sh_cnt <= P_DTO_CYCLES + 4) else $error("tx rx short kept driver");
    hot_drv_a: assert property (i_over_temp |=> !o_drv_en) else $error("driver on when hot");
    hot_ind_a: assert property (i_over_temp |-> ##2 !o_fault_n) else $error("hot not shown");
    off_rec_a: assert property (!o_drv_en |-> o_drv_tx) else $error("bus not recessive");
    rx_mirror_a: assert property ($past(i_rst_n) |-> o_rx == $past(i_bus_rx)) else $error("rx stale");
    bus_ans_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("no bus answer");
    bus_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("long answer");
endmodule
bind cfm_fault_monitor cfm_fault_monitor_asserts #(.P_DTO_CYCLES(P_DTO_CYCLES), .P_BUSDOM_CYCLES(P_BUSDOM_CYCLES))
    u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tx(i_tx), .i_txrx_short(i_txrx_short),
    .i_over_temp(i_over_temp), .i_bus_rx(i_bus_rx), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest), .o_rx(o_rx), .o_fault_n(o_fault_n), .o_drv_en(o_drv_en),
    .o_drv_tx(o_drv_tx));
`default_nettype wire

// ### tb/cfm_ctrl_model.sv
/* Controller model: sends bits on tx on request.
   Assumes length and count stay put while busy. */
`default_nettype none
module cfm_ctrl_model (
    input  wire logic       i_ref_clk, i_rst_n, i_go,
    input  wire logic [7:0] i_bit_len, i_bits,
    output logic            o_tx, o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_reg, cyc_reg;
    // Each bit: low, then high, i_bit_len cycles each
    assign o_tx = (left_reg == 8'h00) || (cyc_reg >= i_bit_len);
    assign o_busy = left_reg != 8'h00;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            left_reg <= 8'h00;
            cyc_reg <= 8'h00;
        end else if (i_go && !o_busy) begin
            left_reg <= i_bits;
            cyc_reg <= 8'h00;
        end else if (o_busy) begin
            cyc_reg <= (cyc_reg == 2 * i_bit_len - 1) ? 8'h00 : cyc_reg + 8'h01;
            left_reg <= (cyc_reg == 2 * i_bit_len - 1) ? left_reg - 8'h01 : left_reg;
        end
    end
endmodule
`default_nettype wire

// ### tb/cfm_fault_monitor_tb.sv
/* Bench of the fault monitor: bus tasks and one task per fault.
   Assumes the controller model and the bound checker. */
`default_nettype none
module cfm_fault_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cfm_pkg::*;
    logic clk = 0, rst_n = 0, go = 0, rd = 0, wr = 0, bus_rx = 1, bsh = 0, txs = 0, otmp = 0;
    logic [3:0] adr = 4'h0;
    logic [7:0] blen = 8'h03, nbit = 8'h01;
    logic [31:0] wd = 32'h0, q, rdat;
    logic tx, rx, fn, den, dtx, wrq, busy;
    int err_total = 0, check_count = 0, cyc = 0;
    cfm_ctrl_model u_ctl (.i_ref_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_bit_len(blen), .i_bits(nbit),
        .o_tx(tx), .o_busy(busy));
    cfm_fault_monitor #(.P_DTO_CYCLES(20), .P_BUSDOM_CYCLES(40)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_tx(tx), .o_rx(rx), .o_fault_n(fn), .i_bus_rx(bus_rx), .i_bus_short(bsh), .i_txrx_short(txs),
        .i_over_temp(otmp), .o_drv_en(den), .o_drv_tx(dtx), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wrq));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pins as {fault_n, drv_en, drv_tx}
    task automatic pins(input logic [2:0] exp);
        cmp({29'h0, fn, den, dtx}, {29'h0, exp});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    // Held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
        end while (wrq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic start(input logic [7:0] l, input logic [7:0] n);
        blen <= l;
        nbit <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic idle();
        do begin
            @(posedge clk);
        end while (busy !== 1'b0);
        tick(2);
    endtask
    task automatic send(input logic [7:0] l, input logic [7:0] n);
        start(l, n);
        idle();
    endtask
    task automatic t_reset();
        bus(1'b0, REG_STATUS, 32'h0);
        cmp(q, (32'(CFM_STANDBY) << ST_MODE_LSB) | (32'h1 << ST_FAULT_N));
        bus(1'b0, 4'h2, 32'h0);
        cmp(q, RD_UNMAPPED);
    endtask
    task automatic t_clamp();
        start(8'h3C, 8'h01);
        bus(1'b1, REG_MODE, 32'(CFM_NORMAL));
        tick(3);
        pins(3'h5);
        bus(1'b0, REG_STATUS, 32'h0);
        cmp({31'h0, q[ST_TX_LOW]}, 32'h1);
        idle();
        pins(3'h5);
        bus_rx <= 1'b0;
        tick(4);
        bus_rx <= 1'b1;
        pins(3'h7);
    endtask
    task automatic t_dto();
        start(8'h1E, 8'h01);
        tick(27);
        pins(3'h5);
        idle();
        pins(3'h7);
    endtask
    task automatic t_short();
        bsh <= 1'b1;
        send(8'h03, 8'h03);
        pins(3'h7);
        send(8'h03, 8'h01);
        pins(3'h3);
        bsh <= 1'b0;
        send(8'h03, 8'h03);
        pins(3'h3);
        send(8'h03, 8'h01);
        pins(3'h7);
    endtask
    task automatic t_local();
        bus_rx <= 1'b0;
        tick(50);
        pins(3'h7);
        bus(1'b0, REG_STATUS, 32'h0);
        cmp({31'h0, q[ST_BUS_DOM]}, 32'h1);
        bus(1'b1, REG_MODE, 32'(CFM_SILENT));
        tick(3);
        cmp({31'h0, fn}, 32'h0);
        bus(1'b1, REG_MODE, 32'(CFM_NORMAL));
        tick(3);
        pins(3'h7);
        bus_rx <= 1'b1;
    endtask
    task automatic t_hot();
        otmp <= 1'b1;
        tick(4);
        pins(3'h1);
        otmp <= 1'b0;
        tick(4);
        pins(3'h7);
    endtask
    task automatic t_txrx();
        txs <= 1'b1;
        tick(27);
        pins(3'h5);
        txs <= 1'b0;
        bus_rx <= 1'b0;
        send(8'h01, 8'h01);
        bus_rx <= 1'b1;
        pins(3'h7);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_clamp();
        t_dto();
        t_short();
        t_local();
        t_hot();
        t_txrx();
        report_and_stop();
    end
endmodule
`default_nettype wire
